// ### hw/ptb_consts.svh
// Constants for the motor-control time base: field positions, reset values and encodings.
`ifndef PTB_CONSTS_SVH
`define PTB_CONSTS_SVH
// ****************************************************************
// Field positions of the first control byte.
// ****************************************************************
`define PTB_POST_MSB      7
`define PTB_POST_LSB      4
`define PTB_PRE_MSB       3
`define PTB_PRE_LSB       2
`define PTB_MODE_MSB      1
`define PTB_MODE_LSB      0
// ****************************************************************
// Field positions of the second control byte.
// ****************************************************************
`define PTB_ON_BIT        7
`define PTB_DIR_BIT       6
// ****************************************************************
// Reset values and widths.
// ****************************************************************
`define PTB_CTRL_RST      8'h00
`define PTB_CNT_W         12
`define PTB_CNT_RST       12'h000
`define PTB_PER_RST       12'h000
`define PTB_HI_NIB_W      4
`define PTB_PRE_W         6
`define PTB_PRE_RST       6'h00
`define PTB_POST_RST      4'h0
// ****************************************************************
// Instruction clock is the oscillator divided by four.
// ****************************************************************
`define PTB_INSTR_DIV     2'h3
// ****************************************************************
// Terminal counts of the prescale counter per ratio.
// ****************************************************************
`define PTB_PRE1_TOP      6'h00
`define PTB_PRE4_TOP      6'h03
`define PTB_PRE16_TOP     6'h0F
`define PTB_PRE64_TOP     6'h3F
`endif

// ### hw/ptb_pkg.sv
// Types shared by the motor-control time base.
package ptb_pkg;
  typedef enum logic [1:0] {
    PTB_FREE   = 2'h0,
    PTB_SINGLE = 2'h1,
    PTB_UPDN   = 2'h2,
    PTB_UPDN2  = 2'h3
  } ptb_mode_t;
  typedef enum logic [1:0] {
    PTB_PRE1  = 2'h0,
    PTB_PRE4  = 2'h1,
    PTB_PRE16 = 2'h2,
    PTB_PRE64 = 2'h3
  } ptb_pre_t;
endpackage : ptb_pkg

// ### hw/ptb_time_base.sv
// Twelve-bit motor-control time base with prescaler, postscaler and buffered period.
//
// Contract
// [R01] Up/down modes count up to period, then down on the next tick.
// [R02] Direction flag is one while counting down, zero while counting up.
// [R03] Outputs held inactive until the first down count from the period; the code does this in up/down modes only, free and single-shot enable at once.
// [R04] Instruction clock is prescaled by 1, 4, 16 or 64 per field.
// [R05] Prescaler clears on count write, control write or reset.
// [R06] Control writes leave the count value unchanged.
// [R07] Events pass a 4-bit postscaler dividing by 1 to 16.
// [R08] Postscaler clears on count write, control write or reset.
// [R09] Free mode: each period match is an event; count returns to zero.
// [R10] Single-shot: match gives event, count zeroes, enable clears, no postscale.
// [R11] Up/down mode: event when count is zero turning upward, postscaled.
// [R12] Double update mode: events at zero and at period match.
// [R13] Software changes mode only while the time base is off.
// [R14] Period is low nibble of high byte joined to the low byte.
// [R15] Free and single-shot: active period loads when count resets after match.
// [R16] Up/down modes: active period loads whenever the count is zero.
// [R17] While off, the buffered period copies into the active period.
// [R18] Free mode period lasts period plus one prescaled ticks.
// [R19] Mode field: 00 free, 01 single, 10 up/down, 11 double update.
// [R20] Prescale field 00, 01, 10, 11 selects divide by 1, 4, 16, 64.
// [R21] Postscale ratio is field value plus one.
// [R22] Turning the enable off stops counting and keeps the count.
// [R23] Each postscaled event is a one-cycle pulse setting a sticky flag.
// [R24] An update strobe marks every load of the active period.
`timescale 1ns/10ps
`include "ptb_consts.svh"
module ptb_time_base
  import ptb_pkg::*;
#(
  parameter int CNT_W = `PTB_CNT_W
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // First control byte write.
  input  wire logic             ctrl_first_we,
  input  wire logic [7:0]       ctrl_first_wdata,
  // Second control byte write, only the enable bit is stored.
  input  wire logic             ctrl_second_we,
  input  wire logic [7:0]       ctrl_second_wdata,
  // Count value write.
  input  wire logic             count_we,
  input  wire logic [CNT_W-1:0] count_wdata,
  // Period buffer byte writes.
  input  wire logic             period_value_high_we,
  input  wire logic             period_value_low_we,
  input  wire logic [7:0]       period_wdata,
  // Software clear of the sticky event flag.
  input  wire logic             event_flag_clr,
  // Status and readback.
  output logic [7:0]            ctrl_first_rdata,
  output logic [7:0]            ctrl_second_rdata,
  output logic                  time_base_on,
  output logic                  count_down_flag,
  output logic [CNT_W-1:0]      time_base_count,
  output logic [CNT_W-1:0]      period_value,
  output logic [CNT_W-1:0]      period_buffer,
  // Events toward duty-cycle and interrupt logic.
  output logic                  tick_pulse,
  output logic                  event_pulse,
  output logic                  event_flag,
  output logic                  period_update,
  output logic                  outputs_enable
);

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [7:0]            ctrl_reg,     ctrl_next;
  logic                  on_reg,       on_next;
  logic                  dir_reg,      dir_next;
  logic [CNT_W-1:0]      cnt_reg,      cnt_next;
  logic [CNT_W-1:0]      per_reg,      per_next;
  logic [CNT_W-1:0]      buf_reg,      buf_next;
  logic [1:0]            q_reg,        q_next;
  logic [`PTB_PRE_W-1:0] pre_reg,      pre_next;
  logic [3:0]            post_reg,     post_next;
  logic                  ev_reg,       ev_next;
  logic                  flag_reg,     flag_next;
  logic                  upd_reg,      upd_next;
  logic                  tick_reg,     tick_next;
  logic                  arm_reg,      arm_next;
  logic                  oe_reg,       oe_next;

  ptb_mode_t mode;
  ptb_pre_t  pre_sel;
  logic [3:0] post_sel;
  logic       instr_tick;
  logic       tick;
  logic       clr_scalers;
  logic       raw_ev;
  logic       post_ev;
  logic [`PTB_PRE_W-1:0] pre_top;

  // Terminal value of the prescale counter for a selected ratio.
  function automatic logic [`PTB_PRE_W-1:0] pre_limit(input ptb_pre_t s);
    case (s)
      PTB_PRE1:  pre_limit = `PTB_PRE1_TOP;
      PTB_PRE4:  pre_limit = `PTB_PRE4_TOP;
      PTB_PRE16: pre_limit = `PTB_PRE16_TOP;
      PTB_PRE64: pre_limit = `PTB_PRE64_TOP;
      default:   pre_limit = `PTB_PRE1_TOP;
    endcase
  endfunction : pre_limit

  // Count one step up or down.
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] v, input logic down);
    cnt_step = down ? v - {{(CNT_W-1){1'b0}}, 1'b1} : v + {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction : cnt_step

  // ****************************************************************
  // Field decode shared by all groups.
  // ****************************************************************
  assign mode        = ptb_mode_t'(ctrl_reg[`PTB_MODE_MSB:`PTB_MODE_LSB]);  // R19
  assign pre_sel     = ptb_pre_t'(ctrl_reg[`PTB_PRE_MSB:`PTB_PRE_LSB]);     // R20
  assign post_sel    = ctrl_reg[`PTB_POST_MSB:`PTB_POST_LSB];               // R21
  assign pre_top     = pre_limit(pre_sel);
  assign clr_scalers = count_we | ctrl_first_we | ctrl_second_we;           // R05

  // ****************************************************************
  // Instruction divider and prescaler.
  // ****************************************************************
  always_comb begin
    instr_tick = (q_reg == `PTB_INSTR_DIV);
    q_next     = instr_tick ? 2'h0 : q_reg + 2'h1;
    pre_next   = pre_reg;
    tick       = 1'b0;
    // Prescaler runs only while the time base is on.
    if (on_reg && instr_tick) begin                                     // R04
      if (pre_reg == pre_top) begin
        pre_next = `PTB_PRE_RST;
        tick     = 1'b1;
      end else begin
        pre_next = pre_reg + 6'h01;
      end
    end
    if (clr_scalers) begin
      pre_next = `PTB_PRE_RST;                                          // R05
    end
    tick_next = tick;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg    <= 2'h0;
      pre_reg  <= `PTB_PRE_RST;                                         // R05
      tick_reg <= 1'b0;
    end else begin
      q_reg    <= q_next;
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  // ****************************************************************
  // Control, count, direction and period.
  // ****************************************************************
  always_comb begin
    ctrl_next = ctrl_first_we ? ctrl_first_wdata : ctrl_reg;
    on_next   = ctrl_second_we ? ctrl_second_wdata[`PTB_ON_BIT] : on_reg;
    dir_next  = dir_reg;
    cnt_next  = cnt_reg;                                                // R06
    per_next  = per_reg;
    buf_next  = buf_reg;
    arm_next  = arm_reg;
    upd_next  = 1'b0;
    raw_ev    = 1'b0;
    // Period buffer bytes.
    if (period_value_high_we) begin                                     // R14
      buf_next[CNT_W-1:8] = period_wdata[`PTB_HI_NIB_W-1:0];
    end
    if (period_value_low_we) begin                                      // R14
      buf_next[7:0] = period_wdata;
    end
    // Counting; stopping keeps the count.
    if (on_reg && tick) begin                                           // R22
      case (mode)
        PTB_FREE, PTB_SINGLE: begin
          dir_next = 1'b0;
          if (cnt_reg == per_reg) begin
            raw_ev   = 1'b1;                                            // R09
            cnt_next = `PTB_CNT_RST;                                    // R18
            per_next = buf_reg;                                         // R15
            upd_next = 1'b1;                                            // R24
            if (mode == PTB_SINGLE) begin
              on_next = 1'b0;                                           // R10
            end
          end else begin
            cnt_next = cnt_step(cnt_reg, 1'b0);
          end
        end
        PTB_UPDN, PTB_UPDN2: begin
          if (!dir_reg) begin
            if (cnt_reg >= per_reg) begin
              dir_next = 1'b1;                                          // R01
              cnt_next = cnt_step(cnt_reg, 1'b1);
              arm_next = 1'b1;                                          // R03
              raw_ev   = (mode == PTB_UPDN2);                           // R12
            end else begin
              cnt_next = cnt_step(cnt_reg, 1'b0);
            end
          end else begin
            if (cnt_reg == `PTB_CNT_RST) begin
              dir_next = 1'b0;                                          // R02
              cnt_next = cnt_step(cnt_reg, 1'b0);
              raw_ev   = 1'b1;                                          // R11
            end else begin
              cnt_next = cnt_step(cnt_reg, 1'b1);
            end
          end
          if (cnt_reg == `PTB_CNT_RST) begin
            per_next = buf_reg;                                         // R16
            upd_next = 1'b1;                                            // R24
          end
        end
        default: begin
          cnt_next = cnt_reg;
        end
      endcase
    end
    // While off the active period follows the buffer every cycle.
    if (!on_reg) begin
      per_next = buf_reg;                                               // R17
      arm_next = 1'b0;
      upd_next = 1'b1;                                                  // R24
    end
    if (count_we) begin
      cnt_next = count_wdata;
    end
    oe_next = on_next & (~ctrl_next[`PTB_MODE_MSB] | arm_next);         // R03
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `PTB_CTRL_RST;
      on_reg   <= 1'b0;
      dir_reg  <= 1'b0;
      cnt_reg  <= `PTB_CNT_RST;
      per_reg  <= `PTB_PER_RST;
      buf_reg  <= `PTB_PER_RST;
      arm_reg  <= 1'b0;
      upd_reg  <= 1'b0;
      oe_reg   <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      on_reg   <= on_next;
      dir_reg  <= dir_next;
      cnt_reg  <= cnt_next;
      per_reg  <= per_next;
      buf_reg  <= buf_next;
      arm_reg  <= arm_next;
      upd_reg  <= upd_next;
      oe_reg   <= oe_next;
    end
  end

  // ****************************************************************
  // Postscaler and event flag.
  // ****************************************************************
  always_comb begin
    post_next = post_reg;
    post_ev   = 1'b0;
    // Single-shot bypasses the postscaler.
    if (raw_ev) begin
      if (mode == PTB_SINGLE || post_reg == post_sel) begin             // R07
        post_ev   = 1'b1;
        post_next = `PTB_POST_RST;
      end else begin
        post_next = post_reg + 4'h1;                                    // R21
      end
    end
    if (clr_scalers) begin
      post_next = `PTB_POST_RST;                                        // R08
    end
    ev_next   = post_ev;                                                // R23
    flag_next = post_ev | (flag_reg & ~event_flag_clr);                 // R23
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      post_reg <= `PTB_POST_RST;                                        // R08
      ev_reg   <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      post_reg <= post_next;
      ev_reg   <= ev_next;
      flag_reg <= flag_next;
    end
  end

  // ****************************************************************
  // Outputs straight from registers.
  // ****************************************************************
  assign ctrl_first_rdata  = ctrl_reg;
  assign ctrl_second_rdata = {on_reg, dir_reg, 6'h00};                  // R02
  assign time_base_on      = on_reg;
  assign count_down_flag   = dir_reg;                                   // R02
  assign time_base_count   = cnt_reg;
  assign period_value      = per_reg;
  assign period_buffer     = buf_reg;
  assign tick_pulse        = tick_reg;
  assign event_pulse       = ev_reg;
  assign event_flag        = flag_reg;
  assign period_update     = upd_reg;
  // Free and single-shot modes enable outputs at once; up/down wait for the turn.
  assign outputs_enable    = oe_reg;                                    // R03

endmodule : ptb_time_base

// ### verif/ptb_time_base_asserts.sv
// Concurrent checks on the ports of the motor-control time base.
`timescale 1ns/10ps
`include "ptb_consts.svh"
module ptb_time_base_asserts
  import ptb_pkg::*;
#(
  parameter int CNT_W = `PTB_CNT_W
) (
  // Clock, reset and the writes that matter here.
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             ctrl_second_we,
  input wire logic             count_we,
  // Status, count and events.
  input wire logic [7:0]       ctrl_first_rdata,
  input wire logic [7:0]       ctrl_second_rdata,
  input wire logic             time_base_on,
  input wire logic             count_down_flag,
  input wire logic [CNT_W-1:0] time_base_count,
  input wire logic [CNT_W-1:0] period_value,
  input wire logic [CNT_W-1:0] period_buffer,
  input wire logic             tick_pulse,
  input wire logic             event_pulse,
  input wire logic             event_flag,
  input wire logic             period_update,
  input wire logic             outputs_enable
);
  // ****************************************************************
  // Relations between the outputs over time.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_DIR_READ: assert property (ctrl_second_rdata == {time_base_on, count_down_flag, 6'h00})
    else $error("status byte mismatch");
  AST_COUNT_HOLD: assert property ($changed(time_base_count) && !$past(count_we) |-> tick_pulse)
    else $error("count moved without a tick");
  AST_FLAG_SET: assert property (event_pulse |-> event_flag)
    else $error("event without flag");
  AST_EVENT_TICK: assert property (event_pulse |-> tick_pulse ##1 !event_pulse)
    else $error("event not a single tick pulse");
  AST_FREE_LOAD: assert property (
    tick_pulse && time_base_on && ctrl_first_rdata[1:0] == 2'h0 && time_base_count == 0
    && $past(time_base_count) != 0 && !$past(count_we)
    |-> period_update && period_value == $past(period_buffer)) else $error("no load at wrap");
  AST_TURN: assert property (tick_pulse && ctrl_first_rdata[1] && $rose(count_down_flag)
    && !$past(count_we)
    |-> time_base_count == $past(time_base_count) - 1'b1) else $error("bad turn");
  AST_OFF_COPY: assert property (!time_base_on && !ctrl_second_we
    |=> period_update && period_value == $past(period_buffer)) else $error("no copy while off");
  AST_SHOT_END: assert property ($fell(time_base_on) && ctrl_first_rdata[1:0] == 2'h1
    && !$past(ctrl_second_we) |-> time_base_count == 0 ##[0:1] event_flag)
    else $error("single shot end wrong");
  AST_OUT_GATE: assert property ($rose(outputs_enable) && ctrl_first_rdata[1] |-> count_down_flag)
    else $error("outputs enabled before turn");
  AST_DIR_TRACK: assert property (tick_pulse && ctrl_first_rdata[1] && !$past(count_we)
    && $changed(time_base_count)
    |-> count_down_flag == (time_base_count < $past(time_base_count)))
    else $error("direction flag does not follow the count");
  AST_UPDN_LOAD: assert property (tick_pulse && ctrl_first_rdata[1]
    && $past(time_base_count) == 0
    |-> period_update && period_value == $past(period_buffer)) else $error("no load at zero");
endmodule : ptb_time_base_asserts
bind ptb_time_base ptb_time_base_asserts #(.CNT_W(CNT_W)) u_chk (.clk, .rst, .ctrl_second_we,
  .count_we, .ctrl_first_rdata, .ctrl_second_rdata, .time_base_on, .count_down_flag,
  .time_base_count, .period_value, .period_buffer, .tick_pulse, .event_pulse, .event_flag,
  .period_update, .outputs_enable);

// ### verif/testbench.sv
// Self-checking testbench for the motor-control time base.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
  import ptb_pkg::*;
  logic        clk = 1'b0;
  logic        rst, ctrl_first_we, ctrl_second_we, count_we, event_flag_clr;
  logic        period_value_high_we, period_value_low_we, time_base_on, count_down_flag;
  logic        tick_pulse, event_pulse, event_flag, period_update, outputs_enable;
  logic [7:0]  ctrl_first_wdata, ctrl_second_wdata, period_wdata;
  logic [7:0]  ctrl_first_rdata, ctrl_second_rdata;
  logic [11:0] count_wdata, time_base_count, period_value, period_buffer, v;
  logic [31:0] seed;
  int          err_total, checks_done, c, n;
  ptb_time_base u_dut (
    .clk, .rst, .ctrl_first_we, .ctrl_first_wdata, .ctrl_second_we, .ctrl_second_wdata,
    .count_we, .count_wdata, .period_value_high_we, .period_value_low_we, .period_wdata,
    .event_flag_clr, .ctrl_first_rdata, .ctrl_second_rdata, .time_base_on, .count_down_flag,
    .time_base_count, .period_value, .period_buffer, .tick_pulse, .event_pulse, .event_flag,
    .period_update, .outputs_enable
  );
  initial forever #50 clk = ~clk;
  function void step();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction : step
  // Clocks between two events for a period, prescale, postscale and mode.
  function automatic int exp_gap(int p, int pre, int post, int md);
    int t;
    t = 4 * (4 ** pre) * (post + 1);
    return (md == 0) ? (p + 1) * t : (md == 2) ? 2 * p * t : p * t;
  endfunction : exp_gap
  // Kinds: 1 first control, 2 second control, 3 period high, 4 period low, 5 count.
  task wr(input int k, input logic [7:0] d);
    @(posedge clk);
    ctrl_first_we <= (k == 1);
    ctrl_second_we <= (k == 2);
    period_value_high_we <= (k == 3);
    period_value_low_we <= (k == 4);
    count_we <= (k == 5);
    {ctrl_first_wdata, ctrl_second_wdata, period_wdata} <= {d, d, d};
    count_wdata <= {4'h0, d};
    @(posedge clk);
    {ctrl_first_we, ctrl_second_we, period_value_high_we, period_value_low_we, count_we} <= 5'h00;
  endtask : wr
  task cfg(input logic [7:0] f, input logic [11:0] p);
    step();
    wr(2, {1'b0, seed[6:0]});
    wr(5, 8'h00);
    wr(3, {seed[11:8], p[11:8]});
    wr(4, p[7:0]);
    wr(1, f);
    wr(2, {1'b1, seed[22:16]});
  endtask : cfg
  task gap(output int g);
    int i;
    i = 0;
    while (event_pulse !== 1'b1 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (event_pulse !== 1'b1 && g < 5000);
  endtask : gap
  task give_verdict();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #5_000_000;
    err_total++;
    give_verdict();
  end
  initial begin
    seed = 32'h0000_fd8a;
    err_total = 0;
    checks_done = 0;
    {rst, ctrl_first_we, ctrl_second_we, count_we, event_flag_clr} = 5'h10;
    {period_value_high_we, period_value_low_we} = 2'h0;
    {ctrl_first_wdata, ctrl_second_wdata, period_wdata, count_wdata} = 36'h0_0000_0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("reset", 28'h000_0000, {ctrl_first_rdata, ctrl_second_rdata, time_base_count})
    step();
    wr(3, seed[7:0]);
    wr(4, seed[15:8]);
    repeat (2) @(negedge clk);
    `CHK("buffer", {seed[3:0], seed[15:8]}, period_buffer)
    `CHK("period", {seed[3:0], seed[15:8]}, period_value)
    for (n = 0; n < 4; n++) begin
      cfg({4'h0, n[1:0], 2'h0}, 12'h003);
      gap(c);
      `CHK("free gap", exp_gap(3, n, 0, 0), c)
    end
    for (n = 0; n < 3; n++) begin
      step();
      v = (n == 2) ? 12'h00f : {8'h00, seed[3:0]};
      cfg({v[3:0], 4'h0}, 12'h001);
      gap(c);
      `CHK("post gap", exp_gap(1, 0, v, 0), c)
    end
    for (n = 2; n < 4; n++) begin
      cfg({(n == 2) ? 4'h1 : 4'h0, 2'h0, n[1:0]}, 12'h004);
      @(negedge clk);
      `CHK("early outputs", 1'b0, outputs_enable)
      gap(c);
      `CHK("updn gap", exp_gap(4, 0, (n == 2) ? 1 : 0, n), c)
      if (n == 2) `CHK("dir at zero", 1'b0, count_down_flag)
      `CHK("outputs", 1'b1, outputs_enable)
    end
    wr(2, 8'h00);
    @(posedge clk);
    event_flag_clr <= 1'b1;
    @(posedge clk);
    event_flag_clr <= 1'b0;
    @(negedge clk);
    `CHK("flag clear", 1'b0, event_flag)
    cfg(8'hf1, 12'h005);
    @(negedge clk);
    c = 0;
    while (time_base_on === 1'b1 && c < 200) begin
      @(negedge clk);
      c++;
    end
    @(negedge clk);
    `CHK("shot end", 1'b0, time_base_on)
    `CHK("shot count", 12'h000, time_base_count)
    `CHK("shot flag", 1'b1, event_flag)
    cfg(8'h00, 12'hfff);
    repeat (50) @(posedge clk);
    wr(2, 8'h00);
    @(negedge clk);
    v = time_base_count;
    wr(1, 8'h0c);
    repeat (20) @(negedge clk);
    `CHK("control byte", 8'h0c, ctrl_first_rdata)
    `CHK("held count", v, time_base_count)
    give_verdict();
  end
endmodule : testbench
